// *** bat_cfg.svh ***
// Constants for the bulk APDU session controller: offsets, codes and the session count.
// Operation
// - P1 b3 set means command carries data; clear means response expected with length.
// - P1 b2 set aborts the addressed session; clear continues it.
// - P1 b1 asks to resend latest response; meaningless and zero when b3 set.
// - All eight P2 bits count blocks still to come from terminal.
// - Data is one TLV object: tag, one or two length bytes, value.
// - Lengths 0..127 take one byte; 128..255 take 0x81 then the value.
// - Only tag 0x80, secure channel data, is allowed; others are reserved.
// - Every command of a session uses the tag of its opening command.
// - Normal answer is 0x92 with condition flags in the second status byte.
// - Retransmit flag: zero sends next block, one resends previous block.
// - Proactive flag set when a proactive message is pending.
// - Status carries the session that owns the pending response block.
// - Data-available flag: zero means session complete, one means more blocks.
// - Returning not-enough-memory 0x6A84 aborts the session.
// - Card may return response data before all terminal data arrives.
// - Response TLV uses the tag and length format of the session's command.
// - P1 b8..b7 hold a two-bit session number, up to four sessions.
// - On receipt of the last terminal block the card answers data-ongoing.
`ifndef BAT_CFG_SVH
`define BAT_CFG_SVH
`define BAT_OFS_CMD      8'h00
`define BAT_OFS_EXT      8'h04
`define BAT_OFS_RSPCTL   8'h08
`define BAT_OFS_STATUS   8'h0C
`define BAT_OFS_RSPTLV   8'h10
`define BAT_OFS_PEND     8'h14
`define BAT_TAG_SC       8'h80
`define BAT_LEN_LONG     8'h81
`define BAT_SW1_ONGOING  8'h92
`define BAT_SW1_ERR      8'h6A
`define BAT_SW2_NOMEM    8'h84
`define BAT_SW2_BADDATA  8'h80
`define BAT_RESP_OKAY    2'h0
`define BAT_RESP_SLVERR  2'h2
`define BAT_NSESS        4
`endif

// *** bat_pkg.sv ***
// Types shared by the bulk APDU session controller.
package bat_pkg;
  typedef struct packed {
    logic [1:0] sess;
    logic [2:0] rfu;
    logic       has_data;
    logic       abort;
    logic       retx;
  } bat_p1_s;
  typedef struct packed {
    logic       active;
    logic [7:0] tag;
    logic [7:0] remain;
    logic [7:0] last_sw2;
    logic [7:0] last_len;
  } bat_sess_s;
  typedef enum logic [1:0] {
    BAT_ST_IDLE = 2'b00,
    BAT_ST_READ = 2'b01,
    BAT_ST_EVAL = 2'b10
  } bat_state_e;
endpackage

// *** bat_sess_mem.sv ***
// Per-session state store with registered read data.
`timescale 1ns/1ps
`default_nettype none
module bat_sess_mem #(
  parameter int W = 33,
  parameter int D = 4,
  parameter int A = 2
) (
  // Clock and reset.
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Write port.
  input  wire logic         we,
  input  wire logic [A-1:0] waddr,
  input  wire logic [W-1:0] wdata,
  // Read port.
  input  wire logic [A-1:0] raddr,
  output logic      [W-1:0] rdata_q
);
  logic [W-1:0] mem_q [D];

  // Entries clear on reset so every session starts closed.
  for (genvar i = 0; i < D; i++) begin : g_ent
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mem_q[i] <= '0;
      end else if (we && waddr == A'(i)) begin
        mem_q[i] <= wdata;
      end
    end
  end

  // Read data is registered; a write in the same cycle is seen one cycle later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem_q[raddr];
    end
  end
endmodule
`default_nettype wire

// *** bat_top.sv ***
// Bulk APDU session controller: AXI4-Lite registers, P1/P2 decode, TLV checks and status building.
`timescale 1ns/1ps
`default_nettype none
`include "bat_cfg.svh"
module bat_top (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address and data.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address and data.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  bat_pkg::bat_state_e st_q;
  bat_pkg::bat_p1_s    p1_q;
  bat_pkg::bat_sess_s  ent, nxt;
  logic [32:0]         ent_raw;
  logic [7:0]          p2_q, tag_q, l0_q, l1_q, le_q;
  logic [7:0]          pend_q [`BAT_NSESS];
  logic [7:0]          pend_nx [`BAT_NSESS];
  logic [7:0]          rlen_q, sw1_q, sw2_q, rtag_q, rl0_q, rl1_q;
  logic [7:0]          ev_sw1, ev_sw2, ev_len, ev_tag;
  logic [1:0]          rln_q, psess;
  logic                proact_q, nomem_q, resend_q, done_q, rvld_q;
  logic                ev_rsp, pany, retx, len_ok, tag_ok;
  logic                wr_go, wr_hs, rd_hs;
  logic [7:0]          wofs;

  assign ent = bat_pkg::bat_sess_s'(ent_raw);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  // Address and data are taken together in one pulse once both are offered.
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign wr_hs = s_axi_awready && s_axi_awvalid;
  assign wofs  = {s_axi_awaddr[7:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BAT_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_hs) begin
        s_axi_bvalid <= 1'b1;
        // Only the three writable words are mapped; a command while busy is refused.
        if (wofs == `BAT_OFS_CMD) begin
          s_axi_bresp <= (st_q != bat_pkg::BAT_ST_IDLE) ? `BAT_RESP_SLVERR : `BAT_RESP_OKAY;
        end else if (wofs == `BAT_OFS_EXT || wofs == `BAT_OFS_RSPCTL) begin
          s_axi_bresp <= `BAT_RESP_OKAY;
        end else begin
          s_axi_bresp <= `BAT_RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read under way, data registered with the answer.
  assign rd_hs = s_axi_arready && s_axi_arvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `BAT_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `BAT_RESP_OKAY;
        unique case ({s_axi_araddr[7:2], 2'b00})
          `BAT_OFS_STATUS: s_axi_rdata <= {13'h0000, rvld_q, done_q, (st_q != bat_pkg::BAT_ST_IDLE), sw1_q, sw2_q};
          `BAT_OFS_RSPTLV: s_axi_rdata <= {6'h00, rln_q, rl1_q, rl0_q, rtag_q};
          `BAT_OFS_PEND:   s_axi_rdata <= {pend_q[3], pend_q[2], pend_q[1], pend_q[0]};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BAT_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written command and response-control words.

  // A command word write starts decoding; the extension word must be written first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p1_q  <= '0;
      p2_q  <= 8'h00;
      tag_q <= 8'h00;
      l0_q  <= 8'h00;
      l1_q  <= 8'h00;
      le_q  <= 8'h00;
    end else if (wr_hs && wofs == `BAT_OFS_CMD && st_q == bat_pkg::BAT_ST_IDLE) begin
      p1_q  <= bat_pkg::bat_p1_s'(s_axi_wdata[7:0]);
      p2_q  <= s_axi_wdata[15:8];
      tag_q <= s_axi_wdata[23:16];
      l0_q  <= s_axi_wdata[31:24];
    end else if (wr_hs && wofs == `BAT_OFS_EXT) begin
      l1_q <= s_axi_wdata[7:0];
      le_q <= s_axi_wdata[15:8];
    end
  end

  // Card-side firmware flags; they are levels it sets and clears itself.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rlen_q   <= 8'h00;
      proact_q <= 1'b0;
      nomem_q  <= 1'b0;
      resend_q <= 1'b0;
    end else if (wr_hs && wofs == `BAT_OFS_RSPCTL) begin
      rlen_q   <= s_axi_wdata[15:8];
      proact_q <= s_axi_wdata[16];
      nomem_q  <= s_axi_wdata[17];
      resend_q <= s_axi_wdata[18];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencing and per-session state.

  // Launch, read the session entry, then evaluate in one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= bat_pkg::BAT_ST_IDLE;
    end else begin
      unique case (st_q)
        bat_pkg::BAT_ST_IDLE: if (wr_hs && wofs == `BAT_OFS_CMD) st_q <= bat_pkg::BAT_ST_READ;
        bat_pkg::BAT_ST_READ: st_q <= bat_pkg::BAT_ST_EVAL;
        bat_pkg::BAT_ST_EVAL: st_q <= bat_pkg::BAT_ST_IDLE;
        default:              st_q <= bat_pkg::BAT_ST_IDLE;
      endcase
    end
  end

  // Four entries, addressed by the session number in P1.
  bat_sess_mem #(.W(33), .D(`BAT_NSESS), .A(2)) u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (st_q == bat_pkg::BAT_ST_EVAL),
    .waddr   (p1_q.sess),
    .wdata   (nxt),
    .raddr   (p1_q.sess),
    .rdata_q (ent_raw)
  );

  // Decode of one command; reserved P1 bits are never looked at.
  always_comb begin
    retx   = p1_q.retx && !p1_q.has_data;
    len_ok = !l0_q[7] || (l0_q == `BAT_LEN_LONG && l1_q[7]);
    tag_ok = tag_q == `BAT_TAG_SC && (!ent.active || ent.tag == tag_q);
    nxt    = ent;
    ev_sw1 = `BAT_SW1_ONGOING;
    ev_sw2 = 8'h00;
    ev_rsp = 1'b0;
    ev_len = rlen_q;
    ev_tag = ent.tag;
    for (int i = 0; i < `BAT_NSESS; i++) pend_nx[i] = pend_q[i];
    if (p1_q.abort) begin
      nxt = '0;
      pend_nx[p1_q.sess] = 8'h00;
    end else if (nomem_q) begin
      nxt    = '0;
      ev_sw1 = `BAT_SW1_ERR;
      ev_sw2 = `BAT_SW2_NOMEM;
      pend_nx[p1_q.sess] = 8'h00;
    end else if (p1_q.has_data) begin
      if (!(tag_ok && len_ok)) begin
        ev_sw1 = `BAT_SW1_ERR;
        ev_sw2 = `BAT_SW2_BADDATA;
      end else begin
        nxt.active = 1'b1;
        nxt.tag    = tag_q;
        nxt.remain = p2_q;
      end
    end else if (!retx && pend_q[p1_q.sess] != 8'h00) begin
      pend_nx[p1_q.sess] = pend_q[p1_q.sess] - 8'h01;
      ev_rsp = 1'b1;
    end
    // Lowest session with blocks waiting owns the reported session number.
    pany  = 1'b0;
    psess = p1_q.sess;
    for (int i = `BAT_NSESS - 1; i >= 0; i--) begin
      if (pend_nx[i] != 8'h00) begin
        pany  = 1'b1;
        psess = 2'(i);
      end
    end
    if (ev_sw1 == `BAT_SW1_ONGOING) begin
      // Reserved top bits stay zero.
      ev_sw2 = {3'b000, resend_q, proact_q, psess, pany};
      if (retx) begin
        ev_sw2 = ent.last_sw2;
        ev_len = ent.last_len;
        ev_rsp = ent.active;
      end else begin
        nxt.last_sw2 = ev_sw2;
        if (ev_rsp) nxt.last_len = rlen_q;
      end
      if (!p1_q.abort && nxt.remain == 8'h00 && pend_nx[p1_q.sess] == 8'h00 && !retx) nxt.active = 1'b0;
    end
    if (p1_q.has_data) ev_tag = tag_q;
  end

  // Pending response blocks per session: firmware loads, retrieval counts down.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `BAT_NSESS; i++) pend_q[i] <= 8'h00;
    end else if (wr_hs && wofs == `BAT_OFS_RSPCTL) begin
      pend_q[s_axi_wdata[1:0]] <= s_axi_wdata[31:24];
    end else if (st_q == bat_pkg::BAT_ST_EVAL) begin
      for (int i = 0; i < `BAT_NSESS; i++) pend_q[i] <= pend_nx[i];
    end
  end

  // Status word and response TLV header, held until the next command finishes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw1_q  <= 8'h00;
      sw2_q  <= 8'h00;
      done_q <= 1'b0;
      rvld_q <= 1'b0;
      rtag_q <= 8'h00;
      rl0_q  <= 8'h00;
      rl1_q  <= 8'h00;
      rln_q  <= 2'h0;
    end else if (st_q == bat_pkg::BAT_ST_EVAL) begin
      sw1_q  <= ev_sw1;
      sw2_q  <= ev_sw2;
      done_q <= 1'b1;
      rvld_q <= ev_rsp;
      rtag_q <= ev_tag;
      // Long form only when the top bit is set, keeping the shortest encoding.
      rl0_q  <= ev_len[7] ? `BAT_LEN_LONG : ev_len;
      rl1_q  <= ev_len[7] ? ev_len : 8'h00;
      rln_q  <= ev_len[7] ? 2'h2 : 2'h1;
    end else if (wr_hs && wofs == `BAT_OFS_CMD) begin
      done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_SEQ: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == bat_pkg::BAT_ST_READ |=> st_q == bat_pkg::BAT_ST_EVAL ##1 st_q == bat_pkg::BAT_ST_IDLE)
    else $error("Command sequence broken.");
  AST_NOMEM: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == bat_pkg::BAT_ST_EVAL && nomem_q && !p1_q.abort |=> sw1_q == 8'h6A && sw2_q == 8'h84
      && pend_q[$past(p1_q.sess)] == 8'h00)
    else $error("Memory-full status or abort missing.");
  AST_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == bat_pkg::BAT_ST_EVAL && p1_q.abort |=> sw1_q == 8'h92 && pend_q[$past(p1_q.sess)] == 8'h00)
    else $error("Abort did not clear session.");
  AST_BADTAG: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == bat_pkg::BAT_ST_EVAL && p1_q.has_data && tag_q != 8'h80 && !p1_q.abort && !nomem_q
      |=> sw1_q == 8'h6A && sw2_q == 8'h80)
    else $error("Reserved tag accepted.");
  AST_SW2_RFU: assert property (@(posedge aclk) disable iff (!aresetn)
    done_q && sw1_q == 8'h92 |-> sw2_q[7:5] == 3'b000)
    else $error("Reserved status bits set.");
  AST_LEN_FMT: assert property (@(posedge aclk) disable iff (!aresetn)
    rln_q == 2'h2 |-> rl0_q == 8'h81 && rl1_q[7])
    else $error("Long length form malformed.");
  AST_RETX_IGN: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == bat_pkg::BAT_ST_EVAL && p1_q.has_data && p1_q.retx |=> !rvld_q)
    else $error("Retransmit honoured with command data.");
  AST_AVAIL: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == bat_pkg::BAT_ST_EVAL && ev_sw1 == 8'h92 && !retx
      |=> sw2_q[0] == ((pend_q[0] | pend_q[1] | pend_q[2] | pend_q[3]) != 8'h00))
    else $error("Data-available flag wrong.");
  AST_BHOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped.");
  AST_RANS: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_hs |=> s_axi_rvalid)
    else $error("Read answer late.");

  COV_ABORT: cover property (@(posedge aclk) st_q == bat_pkg::BAT_ST_EVAL && p1_q.abort);
  COV_RETX:  cover property (@(posedge aclk) st_q == bat_pkg::BAT_ST_EVAL && retx && ent.active);
  COV_LONG:  cover property (@(posedge aclk) rln_q == 2'h2 && rvld_q);
  COV_MORE:  cover property (@(posedge aclk) done_q && sw1_q == 8'h92 && sw2_q[0]);
endmodule
`default_nettype wire

// *** bat_term_model.sv ***
// Terminal-side partner model: AXI4-Lite master and APDU command word builder.
`timescale 1ns/1ps
`default_nettype none
module bat_term_model (
  // Clock.
  input  wire logic        aclk,
  // Write address and data.
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  // Write response.
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read address and data.
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus at time zero so the card never sees an unknown request.
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Builds a command word; a nonzero block count always carries data, and b1 is cleared only when dat is set.
  function automatic logic [31:0] mk_cmd(input logic [1:0] sess, input logic dat, input logic abt, input logic rtx,
                                         input logic [2:0] rfu, input logic [7:0] p2, input logic [7:0] tag,
                                         input logic [7:0] len);
    bat_pkg::bat_p1_s p1;
    p1 = '{sess: sess, rfu: rfu, has_data: dat | (p2 != 8'h00), abort: abt, retx: rtx & ~dat};
    return {len, tag, p2, p1};
  endfunction

  // One write; a released payload is inverted so stale values cannot pass for live ones.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // One read; rready stays high until the data beat is sampled.
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench for the bulk APDU session controller.
`timescale 1ns/1ps
`default_nettype none
`include "bat_cfg.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          error_cnt = 0;
  int          check_count = 0;

  bat_top u_bat_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  bat_term_model u_bat_term_model (.aclk(aclk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_bat_term_model.axi_write(a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    u_bat_term_model.axi_read(a, d, r);
  endtask

  // Loads EXT and RSPCTL first, then the command; polls done with a bounded count.
  task automatic cmd(input logic [31:0] ext, input logic [31:0] rsp, input logic [31:0] c, output logic [31:0] st);
    int n;
    wr(`BAT_OFS_EXT, ext);
    wr(`BAT_OFS_RSPCTL, rsp);
    wr(`BAT_OFS_CMD, c);
    n = 0;
    st = 32'h0;
    while (st[17] !== 1'b1 && n < 50) begin
      rd(`BAT_OFS_STATUS, st);
      n++;
    end
    // A poll that runs out is a mismatch, not a silent pass.
    `CHK(st[17], 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, and an unmapped address is refused on both channels.
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`BAT_OFS_STATUS, d);
    `CHK(d, 32'h0)
    rd(`BAT_OFS_PEND, d);
    `CHK(d, 32'h0)
    u_bat_term_model.axi_read(8'h18, d, r);
    `CHK({r, d}, {`BAT_RESP_SLVERR, 32'h0})
    u_bat_term_model.axi_write(8'h18, 32'hFFFF_FFFF, r);
    `CHK(r, `BAT_RESP_SLVERR)
    $display("test reset done");
  endtask

  // Data command with reserved P1 bits set; proactive flag and pending blocks reported.
  task automatic t_data();
    logic [31:0] st;
    cmd(32'h0, 32'h0201_1001, u_bat_term_model.mk_cmd(2'd1, 1'b1, 1'b0, 1'b0, 3'h7, 8'h03, 8'h80, 8'h10), st);
    `CHK(st[17:0], 18'h2_920B)
    rd(`BAT_OFS_RSPTLV, st);
    `CHK(st, 32'h0100_1080)
    rd(`BAT_OFS_PEND, st);
    `CHK(st, 32'h0000_0200)
    $display("test data done");
  endtask

  // Two-byte length at its lower boundary, then a bad second byte and a reserved tag.
  task automatic t_len();
    logic [31:0] st;
    logic [31:0] c;
    c = u_bat_term_model.mk_cmd(2'd1, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00, 8'h80, `BAT_LEN_LONG);
    cmd(32'h0000_0080, 32'h0204_8001, c, st);
    `CHK(st[17:0], 18'h2_9213)
    rd(`BAT_OFS_RSPTLV, st);
    `CHK(st, 32'h0280_8180)
    cmd(32'h0000_007F, 32'h0200_0001, c, st);
    `CHK(st[15:0], 16'h6A80)
    cmd(32'h0, 32'h0200_0001, u_bat_term_model.mk_cmd(2'd1, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00, 8'h8B, 8'h10), st);
    `CHK(st[15:0], 16'h6A80)
    $display("test length done");
  endtask

  // Response requests drain the pending blocks; a retransmit repeats the stored answer.
  task automatic t_resp();
    logic [31:0] st;
    logic [31:0] c;
    c = u_bat_term_model.mk_cmd(2'd1, 1'b0, 1'b0, 1'b0, 3'h0, 8'h00, 8'h00, 8'h00);
    cmd(32'h0000_3000, 32'h0200_3001, c, st);
    `CHK(st[18:0], 19'h6_9203)
    rd(`BAT_OFS_PEND, st);
    `CHK(st, 32'h0000_0100)
    rd(`BAT_OFS_RSPTLV, st);
    `CHK(st[7:0], `BAT_TAG_SC)
    cmd(32'h0000_3000, 32'h0100_3001, u_bat_term_model.mk_cmd(2'd1, 1'b0, 1'b0, 1'b1, 3'h0, 8'h00, 8'h00, 8'h00), st);
    `CHK(st[15:0], 16'h9203)
    cmd(32'h0000_3000, 32'h0100_3001, c, st);
    `CHK(st[15:0], 16'h9202)
    rd(`BAT_OFS_PEND, st);
    `CHK(st, 32'h0)
    $display("test response done");
  endtask

  // Interleaved sessions, then not-enough-memory and an abort.
  task automatic t_inter();
    logic [31:0] st;
    logic [31:0] c;
    c = u_bat_term_model.mk_cmd(2'd3, 1'b1, 1'b0, 1'b0, 3'h0, 8'h01, 8'h80, 8'h05);
    wr(`BAT_OFS_RSPCTL, 32'h0100_0002);
    cmd(32'h0, 32'h0000_0003, c, st);
    `CHK(st[15:0], 16'h9205)
    rd(`BAT_OFS_PEND, st);
    `CHK(st, 32'h0001_0000)
    cmd(32'h0, 32'h0002_0003, c, st);
    `CHK(st[15:0], 16'h6A84)
    cmd(32'h0, 32'h0100_0002, u_bat_term_model.mk_cmd(2'd2, 1'b0, 1'b1, 1'b0, 3'h0, 8'h00, 8'h00, 8'h00), st);
    `CHK(st[15:8], `BAT_SW1_ONGOING)
    rd(`BAT_OFS_PEND, st);
    `CHK(st, 32'h0)
    $display("test sessions done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset for four cycles, then the scenarios in order.
  initial begin
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_data();
    t_len();
    t_resp();
    t_inter();
    report_and_stop();
  end

  // Watchdog: the scenarios need well under two thousand cycles.
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
